// [rtl/pif_top.sv]
// peripheral interrupt request flags, enables and request gating
//
// Functional notes
// [R01] A flag is set by its source event regardless of its own enable or the global enable.
// [R02] Software should clear a flag before enabling its source so no stale event fires.
// [R03] Each implemented flag reads one while pending and zero while not pending.
// [R04] Request one holds gate acq, conv done, rx, tx, sync port, capture one, timer two, timer one from bit 7 down.
// [R05] In request one the rx and tx flags are read-only, the other six bits are read-write.
// [R06] Request two holds osc fail, comparator two, comparator one, nv write done and bus collision in bits 7 to 3.
// [R07] Request two keeps capture two in bit 0 and bits 2 and 1 read as zero.
// [R08] Request three holds capture four, capture three, timer six, timer four in bits 5, 4, 3, 1, others zero.
// [R09] All implemented flags reset to zero on every reset.
// [R10] No peripheral flag raises an interrupt unless the peripheral enable bit is set.
// [R11] Each flag is qualified by the enable in the same bit of the matching enable register.
// [R12] The request asserts when a flag and its enable, the peripheral enable and the global enable are all set.
// [R13] A writable flag holds until written or set again, and a same-cycle event beats the write.
`timescale 1ns/100ps
`default_nettype none
module pif_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output var logic hreadyout,
	output var logic [31:0] hrdata,
	output var logic hresp,
	input wire logic gate_acq_evt,
	input wire logic conv_done_evt,
	input wire logic serial_rx_evt,
	input wire logic serial_rx_clr,
	input wire logic serial_tx_evt,
	input wire logic serial_tx_clr,
	input wire logic sync_port_evt,
	input wire logic capture_one_evt,
	input wire logic timer_two_match_evt,
	input wire logic timer_one_overflow_evt,
	input wire logic osc_fail_evt,
	input wire logic comparator_two_evt,
	input wire logic comparator_one_evt,
	input wire logic nv_write_done_evt,
	input wire logic bus_collision_evt,
	input wire logic capture_two_evt,
	input wire logic capture_four_evt,
	input wire logic capture_three_evt,
	input wire logic timer_six_match_evt,
	input wire logic timer_four_match_evt,
	output var logic irq_r
);
	import pif_pkg::*;

	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] rd_addr;
	logic [7:0] rd_data;
	logic [7:0] evt1;
	logic [7:0] evt2;
	logic [7:0] evt3;
	logic [7:0] clr1;
	logic [7:0] req1_r;
	logic [7:0] req2_r;
	logic [7:0] req3_r;
	logic [7:0] en1_r;
	logic [7:0] en2_r;
	logic [7:0] en3_r;
	logic [7:0] ctrl_r;
	logic [7:0] stat;
	logic any_active;
	logic irq_nxt;
	logic wr_req1;
	logic wr_req2;
	logic wr_req3;
	logic wr_en1;
	logic wr_en2;
	logic wr_en3;
	logic wr_ctrl;
	logic [7:0] act1;
	logic [7:0] act2;
	logic [7:0] act3;

	// [R04] request one bit order
	assign evt1[7] = gate_acq_evt;
	assign evt1[6] = conv_done_evt;
	assign evt1[5] = serial_rx_evt;
	assign evt1[4] = serial_tx_evt;
	assign evt1[3] = sync_port_evt;
	assign evt1[2] = capture_one_evt;
	assign evt1[1] = timer_two_match_evt;
	assign evt1[0] = timer_one_overflow_evt;
	// [R06] request two bit order
	assign evt2[7] = osc_fail_evt;
	assign evt2[6] = comparator_two_evt;
	assign evt2[5] = comparator_one_evt;
	assign evt2[4] = nv_write_done_evt;
	assign evt2[3] = bus_collision_evt;
	// [R07] capture two at bit zero
	assign evt2[2:1] = 2'h0;
	assign evt2[0] = capture_two_evt;
	// [R08] request three bit order
	assign evt3[7:6] = 2'h0;
	assign evt3[5] = capture_four_evt;
	assign evt3[4] = capture_three_evt;
	assign evt3[3] = timer_six_match_evt;
	assign evt3[2] = 1'b0;
	assign evt3[1] = timer_four_match_evt;
	assign evt3[0] = 1'b0;

	// serial flags are cleared only by their own peripheral
	always_comb begin
		clr1 = PIF_NONE;
		clr1[PIF_RX_BIT] = serial_rx_clr;
		clr1[PIF_TX_BIT] = serial_tx_clr;
	end

	// one write strobe per register, data phase only
	assign wr_req1 = wr_en && (wr_addr == PIF_OFS_REQ1);
	assign wr_req2 = wr_en && (wr_addr == PIF_OFS_REQ2);
	assign wr_req3 = wr_en && (wr_addr == PIF_OFS_REQ3);
	assign wr_en1 = wr_en && (wr_addr == PIF_OFS_EN1);
	assign wr_en2 = wr_en && (wr_addr == PIF_OFS_EN2);
	assign wr_en3 = wr_en && (wr_addr == PIF_OFS_EN3);
	assign wr_ctrl = wr_en && (wr_addr == PIF_OFS_CTRL);

	pif_ahb_slave u_bus (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hrdata(hrdata),
		.hresp(hresp),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_data)
	);

	// [R05] rx and tx not writable
	pif_flag_bank #(
		.IMPL(PIF_IMPL1),
		.SWWR(PIF_SWWR1)
	) u_req1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_req1),
		.wr_data(wr_data),
		.set_evt(evt1),
		.hw_clr(clr1),
		.flags_r(req1_r)
	);

	// [R06] request two, bits 2 and 1 held low
	pif_flag_bank #(
		.IMPL(PIF_IMPL2),
		.SWWR(PIF_IMPL2)
	) u_req2 (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_req2),
		.wr_data(wr_data),
		.set_evt(evt2),
		.hw_clr(PIF_NONE),
		.flags_r(req2_r)
	);

	// [R08] request three, sparse bits
	pif_flag_bank #(
		.IMPL(PIF_IMPL3),
		.SWWR(PIF_IMPL3)
	) u_req3 (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_req3),
		.wr_data(wr_data),
		.set_evt(evt3),
		.hw_clr(PIF_NONE),
		.flags_r(req3_r)
	);

	// [R11] enable one, same layout as request one
	pif_flag_bank #(
		.IMPL(PIF_IMPL1),
		.SWWR(PIF_IMPL1)
	) u_en1 (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_en1),
		.wr_data(wr_data),
		.set_evt(PIF_NONE),
		.hw_clr(PIF_NONE),
		.flags_r(en1_r)
	);

	// [R11] enable two, same layout as request two
	pif_flag_bank #(
		.IMPL(PIF_IMPL2),
		.SWWR(PIF_IMPL2)
	) u_en2 (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_en2),
		.wr_data(wr_data),
		.set_evt(PIF_NONE),
		.hw_clr(PIF_NONE),
		.flags_r(en2_r)
	);

	// [R11] enable three, same layout as request three
	pif_flag_bank #(
		.IMPL(PIF_IMPL3),
		.SWWR(PIF_IMPL3)
	) u_en3 (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_en3),
		.wr_data(wr_data),
		.set_evt(PIF_NONE),
		.hw_clr(PIF_NONE),
		.flags_r(en3_r)
	);

	// global and peripheral enables
	pif_flag_bank #(
		.IMPL(PIF_IMPL_CTRL),
		.SWWR(PIF_IMPL_CTRL)
	) u_ctrl (
		.hclk(hclk),
		.hresetn(hresetn),
		.wr_en(wr_ctrl),
		.wr_data(wr_data),
		.set_evt(PIF_NONE),
		.hw_clr(PIF_NONE),
		.flags_r(ctrl_r)
	);

	// [R11] flag gated by same-position enable
	assign act1 = req1_r & en1_r;
	assign act2 = req2_r & en2_r;
	assign act3 = req3_r & en3_r;
	assign any_active = |{act1, act2, act3};

	// [R10] peripheral enable gates all
	// [R12] request needs both enables
	assign irq_nxt = any_active && ctrl_r[PIF_PERIPH_EN_BIT] && ctrl_r[PIF_GLOBAL_EN_BIT];

	// request comes straight from a flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// status: any gated flag and the registered request
	always_comb begin
		stat = PIF_NONE;
		stat[PIF_STAT_ANY_BIT] = any_active;
		stat[PIF_STAT_IRQ_BIT] = irq_r;
	end

	// [R03] flags read as stored
	always_comb begin
		case (rd_addr)
			PIF_OFS_REQ1: begin
				rd_data = req1_r;
			end
			PIF_OFS_REQ2: begin
				rd_data = req2_r;
			end
			PIF_OFS_REQ3: begin
				rd_data = req3_r;
			end
			PIF_OFS_EN1: begin
				rd_data = en1_r;
			end
			PIF_OFS_EN2: begin
				rd_data = en2_r;
			end
			PIF_OFS_EN3: begin
				rd_data = en3_r;
			end
			PIF_OFS_CTRL: begin
				rd_data = ctrl_r;
			end
			PIF_OFS_STAT: begin
				rd_data = stat;
			end
			default: begin
				rd_data = PIF_NONE;
			end
		endcase
	end
endmodule
`default_nettype wire

// [rtl/pif_pkg.sv]
// shared constants for the peripheral interrupt flag block
`default_nettype none
package pif_pkg;
	localparam int PIF_DW = 8;
	// register byte offsets
	localparam logic [7:0] PIF_OFS_REQ1 = 8'h00;
	localparam logic [7:0] PIF_OFS_REQ2 = 8'h04;
	localparam logic [7:0] PIF_OFS_REQ3 = 8'h08;
	localparam logic [7:0] PIF_OFS_EN1 = 8'h0C;
	localparam logic [7:0] PIF_OFS_EN2 = 8'h10;
	localparam logic [7:0] PIF_OFS_EN3 = 8'h14;
	localparam logic [7:0] PIF_OFS_CTRL = 8'h18;
	localparam logic [7:0] PIF_OFS_STAT = 8'h1C;
	// values after reset
	localparam logic [7:0] PIF_RST_VAL = 8'h00;
	localparam logic [31:0] PIF_RST_WORD = 32'h0000_0000;
	// implemented and software-writable bit masks
	localparam logic [7:0] PIF_IMPL1 = 8'hFF;
	localparam logic [7:0] PIF_SWWR1 = 8'hCF;
	localparam logic [7:0] PIF_IMPL2 = 8'hF9;
	localparam logic [7:0] PIF_IMPL3 = 8'h3A;
	localparam logic [7:0] PIF_IMPL_CTRL = 8'hC0;
	localparam logic [7:0] PIF_NONE = 8'h00;
	// control register bit positions
	localparam int PIF_GLOBAL_EN_BIT = 7;
	localparam int PIF_PERIPH_EN_BIT = 6;
	// status register bit positions
	localparam int PIF_STAT_ANY_BIT = 0;
	localparam int PIF_STAT_IRQ_BIT = 1;
	// read-only serial flag positions in the first request register
	localparam int PIF_RX_BIT = 5;
	localparam int PIF_TX_BIT = 4;
	// bus encodings
	localparam logic [1:0] PIF_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] PIF_HSIZE_WORD = 3'h2;
	localparam logic PIF_HRESP_OKAY = 1'b0;
	typedef enum logic [0:0] {
		PIF_BUS_IDLE,
		PIF_BUS_RDWAIT
	} pif_bus_st_e;
endpackage
`default_nettype wire

// [rtl/pif_flag_bank.sv]
// one 8-bit bank of sticky flags or plain control bits
`timescale 1ns/100ps
`default_nettype none
module pif_flag_bank #(
	parameter logic [7:0] IMPL = 8'hFF,
	parameter logic [7:0] SWWR = 8'hFF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] set_evt,
	input wire logic [7:0] hw_clr,
	output var logic [7:0] flags_r
);
	import pif_pkg::*;

	genvar gi;
	generate
		for (gi = 0; gi < PIF_DW; gi = gi + 1) begin : g_bit
			if (IMPL[gi]) begin : g_impl
				always_ff @(posedge hclk or negedge hresetn) begin
					// [R09] cleared by reset
					if (!hresetn) begin
						flags_r[gi] <= PIF_RST_VAL[gi];
					// [R01] event sets always
					end else if (set_evt[gi]) begin
						flags_r[gi] <= 1'b1;
					// [R13] write loses to event
					end else if (wr_en && SWWR[gi]) begin
						flags_r[gi] <= wr_data[gi];
					end else if (hw_clr[gi]) begin
						flags_r[gi] <= 1'b0;
					end
				end
			end else begin : g_unimpl
				// [R07] unimplemented reads zero
				always_ff @(posedge hclk or negedge hresetn) begin
					if (!hresetn) begin
						flags_r[gi] <= 1'b0;
					end else begin
						flags_r[gi] <= 1'b0;
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [rtl/pif_ahb_slave.sv]
// ahb-lite slave front end, zero-wait writes, one-wait reads
`timescale 1ns/100ps
`default_nettype none
module pif_ahb_slave (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output var logic hreadyout,
	output var logic [31:0] hrdata,
	output var logic hresp,
	output var logic wr_en,
	output var logic [7:0] wr_addr,
	output var logic [7:0] wr_data,
	output var logic [7:0] rd_addr,
	input wire logic [7:0] rd_data
);
	import pif_pkg::*;

	logic take;
	logic wr_pend_r;
	logic [7:0] addr_r;
	pif_bus_st_e st_r;

	// nonseq or seq with hready high starts a transfer
	assign take = hsel && htrans[1] && hready;
	assign wr_en = wr_pend_r;
	assign wr_addr = addr_r;
	assign wr_data = hwdata[7:0];
	assign rd_addr = addr_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			addr_r <= PIF_RST_VAL;
		end else if (take) begin
			wr_pend_r <= hwrite && (hsize == PIF_HSIZE_WORD);
			addr_r <= haddr[7:0];
		end else begin
			wr_pend_r <= 1'b0;
		end
	end

	// read stalls one cycle so a preceding write is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= PIF_BUS_IDLE;
			hreadyout <= 1'b1;
			hrdata <= PIF_RST_WORD;
		end else begin
			case (st_r)
				PIF_BUS_IDLE: begin
					if (take && !hwrite) begin
						st_r <= PIF_BUS_RDWAIT;
						hreadyout <= 1'b0;
					end
				end
				PIF_BUS_RDWAIT: begin
					hrdata <= {24'h00_0000, rd_data};
					hreadyout <= 1'b1;
					st_r <= PIF_BUS_IDLE;
				end
				default: begin
					st_r <= PIF_BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp <= PIF_HRESP_OKAY;
		end else begin
			hresp <= PIF_HRESP_OKAY;
		end
	end
endmodule
`default_nettype wire

// [test/pif_checker_props.sv]
// bus and request checks on the flag block ports
`timescale 1ns/100ps
`default_nettype none
module pif_checker (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic serial_rx_clr,
	input wire logic serial_tx_clr,
	input wire logic irq_r
);
	logic take;
	logic rd_take;
	logic wr_take;
	logic clr_any;
	assign take = hsel && htrans[1] && hready;
	assign rd_take = take && !hwrite;
	assign wr_take = take && hwrite;
	assign clr_any = serial_rx_clr || serial_tx_clr;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_ready_cause: assert property (!hreadyout |-> $past(rd_take))
		else $error("wait without read");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_data_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_data_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
		else $error("read data moved");
	a_irq_reset: assert property ($rose(hresetn) |-> !irq_r)
		else $error("request high after reset");
	a_irq_fall: assert property ($fell(irq_r) |-> $past(wr_take, 3) || $past(clr_any, 2))
		else $error("request dropped alone");
endmodule
bind pif_top pif_checker pif_checker_i (
	.hclk(hclk),
	.hresetn(hresetn),
	.hsel(hsel),
	.htrans(htrans),
	.hwrite(hwrite),
	.hready(hready),
	.hreadyout(hreadyout),
	.hrdata(hrdata),
	.hresp(hresp),
	.serial_rx_clr(serial_rx_clr),
	.serial_tx_clr(serial_tx_clr),
	.irq_r(irq_r)
);
`default_nettype wire

// [test/pif_periph_model.sv]
// peripherals: one-cycle event and clear pulses
`timescale 1ns/100ps
`default_nettype none
module pif_periph_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [23:0] req,
	input wire logic [1:0] clr_req,
	output var logic [23:0] evt,
	output var logic [1:0] clr
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			evt <= 24'h0;
			clr <= 2'h0;
		end else begin
			evt <= req;
			clr <= clr_req;
		end
	end
endmodule
`default_nettype wire

// [test/tb_peripheral_interrupt_flags.sv]
// self-checking bench for the flag block
`timescale 1ns/100ps
`default_nettype none
module tb_peripheral_interrupt_flags;
	import pif_pkg::*;
	localparam logic [23:0] IM = {PIF_IMPL3, PIF_IMPL2, PIF_IMPL1};
	localparam logic [23:0] SW = {PIF_IMPL3, PIF_IMPL2, PIF_SWWR1};
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0] htrans = 2'h0, cl_req = 2'h0;
	logic [2:0] hsize = PIF_HSIZE_WORD;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, v;
	logic [23:0] ev_req = 24'h0;
	wire logic [23:0] ev;
	wire logic [1:0] cl;
	wire logic hready, hreadyout, hresp, irq_r;
	wire logic [31:0] hrdata;
	int bad_count = 0, checked = 0;
	assign hready = hreadyout;
	pif_periph_model pif_periph_model_i (.hclk, .hresetn, .req(ev_req), .clr_req(cl_req), .evt(ev), .clr(cl));
	pif_top pif_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
		.hrdata, .hresp, .irq_r, .serial_rx_clr(cl[1]), .serial_tx_clr(cl[0]), .gate_acq_evt(ev[7]),
		.conv_done_evt(ev[6]), .serial_rx_evt(ev[5]), .serial_tx_evt(ev[4]), .sync_port_evt(ev[3]),
		.capture_one_evt(ev[2]), .timer_two_match_evt(ev[1]), .timer_one_overflow_evt(ev[0]),
		.osc_fail_evt(ev[15]), .comparator_two_evt(ev[14]), .comparator_one_evt(ev[13]),
		.nv_write_done_evt(ev[12]), .bus_collision_evt(ev[11]), .capture_two_evt(ev[8]),
		.capture_four_evt(ev[21]), .capture_three_evt(ev[20]), .timer_six_match_evt(ev[19]),
		.timer_four_match_evt(ev[17]));
	initial forever #12.5 hclk = ~hclk;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				bad_count++;
				$display("Error at %0t: bus ready timeout", $time);
				stop_test();
			end
			@(posedge hclk);
		end
	endtask
	task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [23:0] e = 24'h0);
		haddr <= {24'h0, a};
		htrans <= PIF_HTRANS_NONSEQ;
		hwrite <= 1'b1;
		hsel <= 1'b1;
		ev_req <= e;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		ev_req <= 24'h0;
		rdy();
	endtask
	task automatic br(input logic [7:0] a, output logic [31:0] d);
		haddr <= {24'h0, a};
		htrans <= PIF_HTRANS_NONSEQ;
		hwrite <= 1'b0;
		hsel <= 1'b1;
		rdy();
		htrans <= 2'h0;
		rdy();
		d = hrdata;
	endtask
	task automatic pulse(input logic [23:0] e, input logic [1:0] c);
		ev_req <= e;
		cl_req <= c;
		@(posedge hclk);
		ev_req <= 24'h0;
		cl_req <= 2'h0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 9; i++) begin
			br(8'(i * 4), v);
			chk(v, 32'h0);
		end
		$display("t_reset done");
	endtask
	task automatic t_sw();
		for (int i = 0; i < 3; i++) begin
			bw(8'(i * 4), 32'hFF);
			br(8'(i * 4), v);
			chk(v, {24'h0, SW[i*8+:8]});
			bw(8'(i * 4), 32'h0);
			br(8'(i * 4), v);
			chk(v, 32'h0);
		end
		hsize <= 3'h0;
		bw(PIF_OFS_REQ2, 32'hFF);
		hsize <= PIF_HSIZE_WORD;
		br(PIF_OFS_REQ2, v);
		chk(v, 32'h0);
		$display("t_sw done");
	endtask
	task automatic t_evt();
		for (int i = 0; i < 24; i++) begin
			if (IM[i]) begin
				pulse(24'h1 << i, 2'h0);
				br(8'(i / 8 * 4), v);
				chk(v, 32'h1 << (i % 8));
				bw(8'(i / 8 * 4), 32'h0);
				br(8'(i / 8 * 4), v);
				chk(v, (i == 4 || i == 5) ? 32'h1 << i : 32'h0);
				pulse(24'h0, (i == 5) ? 2'h2 : 2'h1);
				br(8'(i / 8 * 4), v);
				chk(v, 32'h0);
			end
		end
		$display("t_evt done");
	endtask
	task automatic t_gate();
		bw(PIF_OFS_REQ1, 32'h0);
		bw(PIF_OFS_EN1, 32'h02);
		bw(PIF_OFS_CTRL, 32'hC0);
		pulse(24'h1, 2'h0);
		repeat (2) @(posedge hclk);
		chk(irq_r, 32'h0);
		bw(PIF_OFS_CTRL, 32'h80);
		bw(PIF_OFS_EN1, 32'h01);
		repeat (2) @(posedge hclk);
		chk(irq_r, 32'h0);
		bw(PIF_OFS_CTRL, 32'h40);
		repeat (2) @(posedge hclk);
		chk(irq_r, 32'h0);
		bw(PIF_OFS_CTRL, 32'hC0);
		repeat (2) @(posedge hclk);
		chk(irq_r, 32'h1);
		br(PIF_OFS_STAT, v);
		chk(v, 32'h3);
		bw(PIF_OFS_REQ1, 32'h0);
		repeat (2) @(posedge hclk);
		chk(irq_r, 32'h0);
		$display("t_gate done");
	endtask
	task automatic t_race();
		bw(PIF_OFS_REQ1, 32'h0, 24'h1);
		br(PIF_OFS_REQ1, v);
		chk(v, 32'h1);
		pulse(24'h20, 2'h2);
		br(PIF_OFS_REQ1, v);
		chk(v, 32'h21);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		br(PIF_OFS_REQ1, v);
		chk(v, 32'h0);
		$display("t_race done");
	endtask
	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_sw();
		t_evt();
		t_gate();
		t_race();
		stop_test();
	end
endmodule
`default_nettype wire
